// ### rtl/fst_pkg.sv
/*
  Constants, register layouts and sensor carrier of the fail-safe supply and
  thermal monitor. Assumes a 20 MHz system clock and an APB register bus.
*/
// Behaviour
// - Main supply undervoltage sets its flag when capture enabled, and signals on RXD.
// - Undervoltage also sets the transceiver supply status bit.
// - Transceiver undervoltage raises transceiver failure if enabled and CAN mode is 01.
// - Debounced overvoltage sets its flag when capture enabled, and signals on RXD.
// - Shutdown select 0: overvoltage is only signalled.
// - Sleep variant: shutdown select 1 forces Sleep; a wake or interrupt restores regulator.
// - Other variant: regulator off without mode change until overvoltage flag cleared.
// - Limp home output follows present undervoltage or debounced overvoltage.
// - Overvoltage sleep entry first clears all captured event flags.
// - Overvoltage sleep entry enables CAN wake and both local wake edges.
// - Overvoltage sleep entry clears partial networking enable and config-valid.
// - Overvoltage-caused sleep sets the sleep-by-overvoltage status bit.
// - In Normal/Silent, comparator dominant without RXD past clamp time flags clamping.
// - RXD clamping disables the CAN transmitter.
// - Clamping with both enables: silent transceiver failure, clamp status, transmitter status 0.
// - Clamp detection resets in Sleep, Standby, unpowered, or on RXD dominant.
// - Prewarning with enable sets common and per-block bits; the interrupt follows only in device mode 111 with CAN mode 00.
// - Common prewarning clears only when all blocks are below threshold.
// - CAN overtemperature shutdown puts the transceiver off with bus pins tri-stated.
// - LIN shutdown gives LIN standby; an overheated regulator is disabled.
// - During shutdown wake detection and RXD low signalling of pending events continue.
// - Prewarning interrupt needs enable, CAN mode 00, device mode 111; other CAN modes in 111 give flag only.
// - A captured wake drives RXD low when battery and main supply are present.
package fst_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_WAKECFG = 8'h04;
  localparam logic [7:0] ADDR_EVENT   = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0c;

  // Timing: printed unit first, cycle counts derived (least times round up)
  localparam int CLK_PERIOD_NS = 50;
  localparam int OV_DEB_NS     = 10000;
  localparam int CLAMP_NS      = 1000;
  localparam int OV_DEB_CYC    = (OV_DEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLAMP_CYC     = (CLAMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Mode codes
  localparam logic [2:0] DEV_SLEEP   = 3'h1;
  localparam logic [2:0] DEV_STANDBY = 3'h4;
  localparam logic [2:0] DEV_NORMAL  = 3'h7;
  localparam logic [1:0] CAN_PW_IRQ  = 2'h0;
  localparam logic [1:0] CAN_NORMAL  = 2'h1;
  localparam logic [1:0] CAN_SILENT  = 2'h2;

  // Index of each monitored block in the thermal vectors
  localparam int BLK_LIN  = 0;
  localparam int BLK_CAN  = 1;
  localparam int BLK_MAIN = 2;
  localparam int BLK_SENS = 3;

  typedef struct packed {
    logic [20:0] rsvd;
    logic [2:0]  deviceOperatingModeField;
    logic [1:0]  canOperatingModeField;
    logic        thermalPrewarnEn;
    logic        rxdClampCaptureEn;
    logic        canTransceiverFailureEn;
    logic        overvoltageShutdownSelect;
    logic        supplyOvervoltageCaptureEn;
    logic        supplyUndervoltageCaptureEn;
  } fst_ctrl_t;

  typedef struct packed {
    logic [26:0] rsvd;
    logic        partialNetworkingConfigValid;
    logic        partialNetworkingEn;
    logic        localWakeFallingEn;
    logic        localWakeRisingEn;
    logic        canWakeupEn;
  } fst_wake_t;

  typedef struct packed {
    logic [21:0] rsvd;
    logic [3:0]  blockPrewarn;
    logic        thermalShutdownFlag;
    logic        wakeFlag;
    logic        thermalPrewarnEventFlag;
    logic        canTransceiverFailureFlag;
    logic        supplyOvervoltageFlag;
    logic        supplyUndervoltageFlag;
  } fst_event_t;

  typedef struct packed {
    logic [25:0] rsvd;
    logic        mainLdoOn;
    logic        sleepByOvervoltageStatus;
    logic        thermalPrewarnCommonStatus;
    logic        transmitterActiveStatus;
    logic        rxdClampStatus;
    logic        transceiverSupplyStatus;
  } fst_status_t;

  // Sensor inputs from the analog side
  typedef struct packed {
    logic       supplyUv;
    logic       trxUv;
    logic       supplyOv;
    logic       busLevelComparator;
    logic       rxdRecessive;
    logic       wakeEvent;
    logic       batteryPresent;
    logic       mainPresent;
    logic [3:0] prewarn;
    logic [3:0] shutdown;
  } fst_sense_t;

  // Writable bits of the control registers
  localparam logic [31:0] CTRL_MASK    = 32'h0000_07ff;
  localparam logic [31:0] WAKECFG_MASK = 32'h0000_001f;
  localparam logic [31:0] STATUS_W1C   = 32'h0000_0011;

endpackage

// ### rtl/fst_monitor.sv
/*
  Fail-safe supervisor: supply under/overvoltage capture and reaction, RXD
  recessive clamp detection, overtemperature prewarning and shutdown, with
  RXD event signalling. Assumes asynchronous sensor levels and an APB master.
*/
`timescale 1ns/1ps
module fst_monitor #(
  parameter int CNT_W         = 12,
  parameter bit VARIANT_SLEEP = 1'b1
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire fst_pkg::fst_sense_t sense,
  output logic                   rxdSignal_n,
  output logic                   limpHomeFailureOut,
  output logic                   mainLdoEn,
  output logic                   sensorLdoEn,
  output logic                   canTxEn,
  output logic                   canBusOff,
  output logic                   linStandby,
  output logic [2:0]             deviceMode
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks and counter limits
  if (CNT_W < 2 ||
      fst_pkg::OV_DEB_CYC >= (1 << CNT_W) ||
      fst_pkg::CLAMP_CYC >= (1 << CNT_W)) begin : g_bad_cnt_w
    $error("fst_monitor: CNT_W too small for timing counts");
  end

  localparam logic [CNT_W-1:0] OV_LIM    = CNT_W'(fst_pkg::OV_DEB_CYC);
  localparam logic [CNT_W-1:0] CLAMP_LIM = CNT_W'(fst_pkg::CLAMP_CYC);

  typedef struct packed {
    // Sensor path
    fst_pkg::fst_sense_t  sync1;
    fst_pkg::fst_sense_t  sync2;
    fst_pkg::fst_sense_t  sync3;
    fst_pkg::fst_sense_t  filt;
    fst_pkg::fst_sense_t  prev;

    // Registers
    fst_pkg::fst_ctrl_t   ctrl;
    fst_pkg::fst_wake_t   wake;
    fst_pkg::fst_event_t  evt;
    fst_pkg::fst_status_t stat;

    // Timers and edges
    logic [CNT_W-1:0]     ovCnt;
    logic [CNT_W-1:0]     clampCnt;
    logic                 ovDeb;
    logic                 ovDebPrev;
    logic                 clampDet;
    logic                 clampPrev;
    logic                 trxQuiet;
    logic                 prewarnIrq;

    // Bus answer
    logic [31:0]          rdata;
    logic                 ready;
    logic                 slvErr;

    // Pins
    logic                 rxdN;
    logic                 limp;
    logic                 mainLdo;
    logic                 sensLdo;
    logic                 txEn;
    logic                 busOff;
    logic                 linStby;
  } fst_state_t;

  fst_state_t st_r;
  fst_state_t st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux, shared by read data and error decode
  function automatic logic [32:0] fst_read(input logic [7:0] a,
    input fst_state_t s);
    logic [32:0] r;
    r = {1'b0, 32'h0000_0000};
    unique case (a)
      fst_pkg::ADDR_CTRL:    r = {1'b0, 32'(s.ctrl)};
      fst_pkg::ADDR_WAKECFG: r = {1'b0, 32'(s.wake)};
      fst_pkg::ADDR_EVENT:   r = {1'b0, 32'(s.evt)};
      fst_pkg::ADDR_STATUS:  r = {1'b0, 32'(s.stat)};
      default:               r = {1'b1, 32'h0000_0000};
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    fst_pkg::fst_sense_t f;
    logic                clampWatch;
    logic                ovRise;
    logic                clampRise;
    logic                wakeRise;
    logic [3:0]          newPw;
    logic [3:0]          newSd;
    logic                acc;
    logic                pending;
    logic                ldoOffOv;
    logic [32:0]         rd;

    // Defaults
    f          = st_r.filt;
    clampWatch = 1'b0;
    ovRise     = 1'b0;
    clampRise  = 1'b0;
    wakeRise   = 1'b0;
    newPw      = 4'h0;
    newSd      = 4'h0;
    acc        = 1'b0;
    pending    = 1'b0;
    ldoOffOv   = 1'b0;
    rd         = fst_read(paddr, st_r);
    st_nxt     = st_r;

    // Three-stage synchroniser; a level changes only when stages 2 and 3 agree
    st_nxt.sync1 = sense;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.sync3 = st_r.sync2;
    st_nxt.filt  = (st_r.sync2 & st_r.sync3) |
                   (st_r.filt & (st_r.sync2 | st_r.sync3));
    st_nxt.prev  = st_r.filt;

    // Overvoltage debounce: must persist the full debounce time
    if (!f.supplyOv) begin
      st_nxt.ovCnt = '0;
    end else if (st_r.ovCnt != OV_LIM) begin
      st_nxt.ovCnt = st_r.ovCnt + 1'b1;
    end

    // Debounced level
    st_nxt.ovDeb     = f.supplyOv && (st_r.ovCnt == OV_LIM);
    st_nxt.ovDebPrev = st_r.ovDeb;
    ovRise           = st_r.ovDeb && !st_r.ovDebPrev;

    // Clamp watch only in Normal/Silent and while powered and awake
    clampWatch = (st_r.ctrl.canOperatingModeField == fst_pkg::CAN_NORMAL ||
                  st_r.ctrl.canOperatingModeField == fst_pkg::CAN_SILENT) &&
                 st_r.ctrl.deviceOperatingModeField != fst_pkg::DEV_SLEEP &&
                 st_r.ctrl.deviceOperatingModeField != fst_pkg::DEV_STANDBY &&
                 f.mainPresent;

    if (!clampWatch || !f.rxdRecessive) begin
      st_nxt.clampCnt = '0;
      st_nxt.clampDet = 1'b0;
    end else if (f.busLevelComparator) begin
      if (st_r.clampCnt != CLAMP_LIM) begin
        st_nxt.clampCnt = st_r.clampCnt + 1'b1;
      end else begin
        st_nxt.clampDet = 1'b1;
      end
    end else begin
      st_nxt.clampCnt = '0;
    end

    st_nxt.clampPrev = st_r.clampDet;
    clampRise        = st_r.clampDet && !st_r.clampPrev;

    // APB: one wait state; pready rises in the second access cycle
    st_nxt.ready = psel && penable && !st_r.ready;
    acc          = psel && penable && st_r.ready;

    if (psel && penable && !st_r.ready) begin
      st_nxt.rdata  = pwrite ? 32'h0000_0000 : rd[31:0];
      st_nxt.slvErr = rd[32];
    end else if (acc) begin
      st_nxt.rdata  = 32'h0000_0000;
      st_nxt.slvErr = 1'b0;
    end

    // Writes land with the answer
    if (acc && pwrite && !rd[32]) begin
      unique case (paddr)
        fst_pkg::ADDR_CTRL:    st_nxt.ctrl = fst_pkg::fst_ctrl_t'(pwdata & fst_pkg::CTRL_MASK);
        fst_pkg::ADDR_WAKECFG: st_nxt.wake = fst_pkg::fst_wake_t'(pwdata & fst_pkg::WAKECFG_MASK);
        fst_pkg::ADDR_EVENT:   st_nxt.evt  = st_r.evt & ~fst_pkg::fst_event_t'(pwdata);
        default:               st_nxt.stat = st_r.stat & ~fst_pkg::fst_status_t'(pwdata &
                                                                fst_pkg::STATUS_W1C);
      endcase
    end

    // Hardware events below come after the software clears, so a set wins
    if (f.supplyUv && !st_r.prev.supplyUv) begin
      st_nxt.stat.transceiverSupplyStatus = 1'b1;
      if (st_r.ctrl.supplyUndervoltageCaptureEn) begin
        st_nxt.evt.supplyUndervoltageFlag = 1'b1;
      end
    end

    // Transceiver undervoltage
    if (f.trxUv && !st_r.prev.trxUv && st_r.ctrl.canTransceiverFailureEn &&
        st_r.ctrl.canOperatingModeField == fst_pkg::CAN_NORMAL) begin
      st_nxt.evt.canTransceiverFailureFlag = 1'b1;
      st_nxt.trxQuiet                      = 1'b0;
    end

    if (ovRise && st_r.ctrl.supplyOvervoltageCaptureEn) begin
      st_nxt.evt.supplyOvervoltageFlag = 1'b1;
    end

    // Clamp failure is captured but kept off the RXD pin
    if (clampRise && st_r.ctrl.canTransceiverFailureEn &&
        st_r.ctrl.rxdClampCaptureEn) begin
      if (!st_nxt.evt.canTransceiverFailureFlag) begin
        st_nxt.trxQuiet = 1'b1;
      end
      st_nxt.evt.canTransceiverFailureFlag = 1'b1;
    end

    st_nxt.stat.rxdClampStatus = st_nxt.clampDet && st_r.ctrl.canTransceiverFailureEn &&
                                 st_r.ctrl.rxdClampCaptureEn;
    st_nxt.stat.transmitterActiveStatus = !st_nxt.clampDet;

    // Quiet mark ends with its flag
    if (!st_nxt.evt.canTransceiverFailureFlag) begin
      st_nxt.trxQuiet = 1'b0;
    end

    // Thermal prewarning
    newPw = f.prewarn & ~st_r.prev.prewarn;
    if (st_r.ctrl.thermalPrewarnEn && newPw != 4'h0) begin
      st_nxt.evt.blockPrewarn               = st_nxt.evt.blockPrewarn | newPw;
      st_nxt.stat.thermalPrewarnCommonStatus = 1'b1;
      if (st_r.ctrl.deviceOperatingModeField == fst_pkg::DEV_NORMAL) begin
        st_nxt.evt.thermalPrewarnEventFlag = 1'b1;
        if (st_r.ctrl.canOperatingModeField == fst_pkg::CAN_PW_IRQ) begin
          st_nxt.prewarnIrq = 1'b1;
        end
      end
    end

    if (f.prewarn == 4'h0) begin
      st_nxt.stat.thermalPrewarnCommonStatus = 1'b0;
    end

    // IRQ lives with its flag
    st_nxt.prewarnIrq = st_nxt.prewarnIrq && st_nxt.evt.thermalPrewarnEventFlag;

    // Shutdown capture; wake capture keeps running through it
    newSd = f.shutdown & ~st_r.prev.shutdown;
    if (newSd != 4'h0) begin
      st_nxt.evt.thermalShutdownFlag = 1'b1;
    end

    wakeRise = f.wakeEvent && !st_r.prev.wakeEvent;
    if (wakeRise) begin
      st_nxt.evt.wakeFlag = 1'b1;
    end

    // Leave overvoltage sleep on a wake or any newly captured event
    if (st_r.ctrl.deviceOperatingModeField == fst_pkg::DEV_SLEEP &&
        (wakeRise || (st_nxt.evt & ~st_r.evt) != '0)) begin
      st_nxt.ctrl.deviceOperatingModeField = fst_pkg::DEV_STANDBY;
    end

    // Forced sleep: prepare wake sources so the device can never lock up
    if (VARIANT_SLEEP && ovRise && st_r.ctrl.overvoltageShutdownSelect) begin
      st_nxt.evt                               = '0;
      st_nxt.prewarnIrq                        = 1'b0;
      st_nxt.trxQuiet                          = 1'b0;

      st_nxt.wake.canWakeupEn                  = 1'b1;
      st_nxt.wake.localWakeRisingEn            = 1'b1;
      st_nxt.wake.localWakeFallingEn           = 1'b1;
      st_nxt.wake.partialNetworkingEn          = 1'b0;
      st_nxt.wake.partialNetworkingConfigValid = 1'b0;

      st_nxt.stat.sleepByOvervoltageStatus     = 1'b1;
      st_nxt.ctrl.deviceOperatingModeField     = fst_pkg::DEV_SLEEP;
    end

    // Regulator reaction; select 0 leaves the regulator alone
    if (VARIANT_SLEEP) begin
      ldoOffOv = st_nxt.ctrl.deviceOperatingModeField == fst_pkg::DEV_SLEEP;
    end else begin
      ldoOffOv = st_r.ctrl.overvoltageShutdownSelect &&
                 st_nxt.evt.supplyOvervoltageFlag;
    end

    // Per-block shutdown wins
    st_nxt.mainLdo        = !ldoOffOv && !f.shutdown[fst_pkg::BLK_MAIN];
    st_nxt.sensLdo        = !f.shutdown[fst_pkg::BLK_SENS];
    st_nxt.stat.mainLdoOn = st_nxt.mainLdo;
    st_nxt.busOff         = f.shutdown[fst_pkg::BLK_CAN];
    st_nxt.linStby        = f.shutdown[fst_pkg::BLK_LIN];
    st_nxt.txEn           = !st_nxt.clampDet && !f.shutdown[fst_pkg::BLK_CAN] &&
                            st_nxt.ctrl.canOperatingModeField == fst_pkg::CAN_NORMAL;

    // Undervoltage level and debounced overvoltage
    st_nxt.limp           = f.supplyUv || st_r.ovDeb;

    // RXD low while any signalled flag pends and supplies are present
    pending = st_nxt.evt.supplyUndervoltageFlag || st_nxt.evt.supplyOvervoltageFlag ||
              st_nxt.evt.wakeFlag || st_nxt.evt.thermalShutdownFlag || st_nxt.prewarnIrq ||
              (st_nxt.evt.canTransceiverFailureFlag && !st_nxt.trxQuiet);

    st_nxt.rxdN = !(pending && f.batteryPresent && f.mainPresent);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; outputs idle-safe during reset
  always_ff @(posedge clock) begin
    if (rst) begin
      st_r                              <= '0;
      st_r.rxdN                         <= 1'b1;
      st_r.mainLdo                      <= 1'b1;
      st_r.sensLdo                      <= 1'b1;
      st_r.stat.mainLdoOn               <= 1'b1;
      st_r.stat.transmitterActiveStatus <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign prdata             = st_r.rdata;
  assign pready             = st_r.ready;
  assign pslverr            = st_r.slvErr;

  // Pin-level outputs
  assign rxdSignal_n        = st_r.rxdN;
  assign limpHomeFailureOut = st_r.limp;
  assign mainLdoEn          = st_r.mainLdo;
  assign sensorLdoEn        = st_r.sensLdo;
  assign canTxEn            = st_r.txEn;
  assign canBusOff          = st_r.busOff;
  assign linStandby         = st_r.linStby;
  assign deviceMode         = st_r.ctrl.deviceOperatingModeField;

endmodule

// ### bench/fst_monitor_assertions.sv
/*
  Port-level checks of the fail-safe monitor: bus handshake, limp home,
  thermal shutdown reactions and RXD gating.
  Assumes one clock domain with synchronous active-high reset; bound below.
*/
`timescale 1ns/1ps
module fst_monitor_assertions #(
  parameter int CNT_W = 12
) (
  input wire logic                clock,
  input wire logic                rst,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire fst_pkg::fst_sense_t sense,
  input wire logic                rxdSignal_n,
  input wire logic                limpHomeFailureOut,
  input wire logic                mainLdoEn,
  input wire logic                canTxEn,
  input wire logic                canBusOff,
  input wire logic                linStandby
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, then a single-cycle answer
  a_ready_after_access: assert property (psel && penable && !pready |=> pready)
    else $error("ready missing after access cycle");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_needs_access: assert property (pready |-> psel && penable)
    else $error("ready outside an access");
  a_error_reads_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("refused transfer not clean");
  ////////////////////////////////////////////////////////////
  // Eight cycles cover the input filter plus the output flop
  a_limp_on_uv: assert property (sense.supplyUv [*8] |-> limpHomeFailureOut)
    else $error("limp home not raised on undervoltage");
  a_limp_released: assert property ((!sense.supplyUv && !sense.supplyOv) [*8] |-> !limpHomeFailureOut)
    else $error("limp home stuck without supply fault");
  a_main_ldo_shut: assert property (sense.shutdown[2] [*8] |-> !mainLdoEn)
    else $error("main regulator left on when overheated");
  a_lin_standby: assert property (sense.shutdown[0] [*8] |-> linStandby)
    else $error("lin not in standby when overheated");
  a_can_off: assert property (sense.shutdown[1] [*8] |-> canBusOff && !canTxEn)
    else $error("can not off when overheated");
  a_rxd_unpowered: assert property (!sense.mainPresent [*8] |-> rxdSignal_n)
    else $error("rxd driven without main supply");
  c_refused: cover property (pslverr);
  c_clamp_off: cover property (!canTxEn && !canBusOff);
  c_event_signal: cover property ($fell(rxdSignal_n));
endmodule

bind fst_monitor fst_monitor_assertions #(.CNT_W(CNT_W)) i_fst_monitor_assertions (
  .clock(clock), .rst(rst), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sense(sense), .rxdSignal_n(rxdSignal_n),
  .limpHomeFailureOut(limpHomeFailureOut), .mainLdoEn(mainLdoEn), .canTxEn(canTxEn),
  .canBusOff(canBusOff), .linStandby(linStandby));

// ### bench/fst_host_model.sv
/*
  Far side of the receive path: the RXD line as the monitor senses it.
  Assumes the testbench drives the bus level and any clamp fault.
*/
`timescale 1ns/1ps
module fst_host_model (
  input  wire logic busDominant,
  input  wire logic clampRxd,
  output logic      rxdPin
);
  // RXD mirrors the bus; a short to supply holds it high
  assign rxdPin = clampRxd | ~busDominant;
endmodule

// ### bench/tb_fst_monitor.sv
/*
  Self-checking bench of the fail-safe monitor: APB master, sensor stimulus.
  Assumes the sleep variant and the package timing defaults.
*/
`timescale 1ns/1ps
module tb_fst_monitor;
  typedef struct packed {
    logic [31:0] exp;
    logic [31:0] mask;
    logic        err;
  } fst_note_t;
  logic                clock, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]          paddr;
  logic [31:0]         pwdata, prdata;
  logic                rxdSignal_n, limpHomeFailureOut, mainLdoEn, sensorLdoEn;
  logic                canTxEn, canBusOff, linStandby, busDominant, clampRxd, rxdPin;
  logic [2:0]          deviceMode;
  logic [3:0]          pw;
  fst_pkg::fst_sense_t senseDrv, sense;
  fst_note_t           notes[$];
  fst_note_t           note;
  int                  errors, testsRun;
  integer              seed = 32'hba8608d5;

  fst_monitor i_fst_monitor (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sense(sense), .rxdSignal_n(rxdSignal_n),
    .limpHomeFailureOut(limpHomeFailureOut), .mainLdoEn(mainLdoEn),
    .sensorLdoEn(sensorLdoEn), .canTxEn(canTxEn), .canBusOff(canBusOff),
    .linStandby(linStandby), .deviceMode(deviceMode));
  fst_host_model i_fst_host_model (.busDominant(busDominant), .clampRxd(clampRxd),
    .rxdPin(rxdPin));

  // Sensed RXD comes from the far-side model, the rest from the bench
  always_comb begin
    sense = senseDrv;
    sense.busLevelComparator = busDominant;
    sense.rxdRecessive = rxdPin;
  end

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (errors == 0 && testsRun > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk_pin(input logic [2:0] got, input logic [2:0] exp);
    testsRun++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t pin %0h want %0h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t word %0h want %0h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Full transfer; the answer is noted first and judged by the watcher
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e = 32'h0, input logic [31:0] m = 32'h0,
                     input logic er = 1'b0);
    int n;
    notes.push_back('{e, m, er});
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      $display("CHECK FAILED %0t bus timeout", $time);
      report_and_stop();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0, e, m);
  endtask
  // Watcher: every completed transfer takes the oldest note
  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1) begin
      note = notes.pop_front();
      chk_word(prdata & note.mask, note.exp & note.mask);
      chk_pin({2'h0, pslverr}, {2'h0, note.err});
    end
  end
  initial begin
    cyc(20000);
    errors++;
    $display("CHECK FAILED %0t run timeout", $time);
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, busDominant, clampRxd} = '0;
    rst = 1'b1;
    senseDrv = '0;
    senseDrv.batteryPresent = 1'b1;
    senseDrv.mainPresent = 1'b1;
    cyc(16);
    rst <= 1'b0;
    cyc(6);
    // Reset values and a refused address
    rd(fst_pkg::ADDR_CTRL, 32'h0, 32'hffff_ffff);
    rd(fst_pkg::ADDR_WAKECFG, 32'h0, 32'hffff_ffff);
    rd(fst_pkg::ADDR_EVENT, 32'h0, 32'hffff_ffff);
    rd(fst_pkg::ADDR_STATUS, 32'h24, 32'hffff_ffff);
    apb(1'b1, 8'h10, $random(seed), 32'h0, 32'h0, 1'b1);
    apb(1'b0, 8'h10, 32'h0, 32'h0, 32'hffff_ffff, 1'b1);
    // Undervoltage, pending flags, host clear
    apb(1'b1, fst_pkg::ADDR_CTRL, 32'h49);
    senseDrv.supplyUv <= 1'b1;
    senseDrv.trxUv <= 1'b1;
    cyc(10);
    chk_pin(limpHomeFailureOut, 1);
    chk_pin(rxdSignal_n, 0);
    rd(fst_pkg::ADDR_EVENT, 32'h5, 32'h7);
    rd(fst_pkg::ADDR_STATUS, 32'h1, 32'h1);
    senseDrv.supplyUv <= 1'b0;
    senseDrv.trxUv <= 1'b0;
    cyc(10);
    chk_pin(limpHomeFailureOut, 0);
    chk_pin(rxdSignal_n, 0);
    apb(1'b1, fst_pkg::ADDR_EVENT, 32'h3ff);
    apb(1'b1, fst_pkg::ADDR_STATUS, 32'h11);
    cyc(3);
    chk_pin(rxdSignal_n, 1);
    // Overvoltage, signal only
    apb(1'b1, fst_pkg::ADDR_CTRL, 32'h702);
    senseDrv.supplyOv <= 1'b1;
    cyc(100);
    chk_pin(limpHomeFailureOut, 0);
    cyc(120);
    chk_pin(rxdSignal_n, 0);
    chk_pin(mainLdoEn, 1);
    chk_pin(deviceMode, 3'h7);
    rd(fst_pkg::ADDR_EVENT, 32'h2, 32'h2);
    senseDrv.supplyOv <= 1'b0;
    apb(1'b1, fst_pkg::ADDR_EVENT, 32'h3ff);
    // Overvoltage forcing sleep, then wake
    apb(1'b1, fst_pkg::ADDR_WAKECFG, 32'h18);
    apb(1'b1, fst_pkg::ADDR_CTRL, 32'h706);
    senseDrv.supplyOv <= 1'b1;
    cyc(230);
    chk_pin(mainLdoEn, 0);
    chk_pin(deviceMode, fst_pkg::DEV_SLEEP);
    rd(fst_pkg::ADDR_EVENT, 32'h0, 32'hffff_ffff);
    rd(fst_pkg::ADDR_WAKECFG, 32'h7, 32'hffff_ffff);
    rd(fst_pkg::ADDR_STATUS, 32'h10, 32'h10);
    senseDrv.supplyOv <= 1'b0;
    senseDrv.wakeEvent <= 1'b1;
    cyc(8);
    senseDrv.wakeEvent <= 1'b0;
    chk_pin(deviceMode, fst_pkg::DEV_STANDBY);
    chk_pin(mainLdoEn, 1);
    apb(1'b1, fst_pkg::ADDR_EVENT, 32'h3ff);
    apb(1'b1, fst_pkg::ADDR_STATUS, 32'h11);
    // RXD clamped high while the bus is dominant
    apb(1'b1, fst_pkg::ADDR_CTRL, 32'h758);
    cyc(6);
    chk_pin(canTxEn, 1);
    busDominant <= 1'b1;
    clampRxd <= 1'b1;
    cyc(40);
    chk_pin(canTxEn, 0);
    chk_pin(rxdSignal_n, 1);
    rd(fst_pkg::ADDR_STATUS, 32'h2, 32'h6);
    rd(fst_pkg::ADDR_EVENT, 32'h4, 32'h4);
    clampRxd <= 1'b0;
    cyc(8);
    chk_pin(canTxEn, 1);
    rd(fst_pkg::ADDR_STATUS, 32'h0, 32'h2);
    busDominant <= 1'b0;
    apb(1'b1, fst_pkg::ADDR_EVENT, 32'h3ff);
    // Prewarning on random blocks, common bit drop only when all cool
    apb(1'b1, fst_pkg::ADDR_CTRL, 32'h720);
    pw = 4'($random(seed)) | 4'h9;
    senseDrv.prewarn <= pw;
    cyc(10);
    chk_pin(rxdSignal_n, 0);
    rd(fst_pkg::ADDR_EVENT, {22'h0, pw, 6'h08}, 32'h3c8);
    rd(fst_pkg::ADDR_STATUS, 32'h8, 32'h8);
    senseDrv.prewarn <= 4'h8;
    cyc(8);
    rd(fst_pkg::ADDR_STATUS, 32'h8, 32'h8);
    senseDrv.prewarn <= 4'h0;
    cyc(8);
    rd(fst_pkg::ADDR_STATUS, 32'h0, 32'h8);
    apb(1'b1, fst_pkg::ADDR_EVENT, 32'h3ff);
    apb(1'b1, fst_pkg::ADDR_CTRL, 32'h760);
    senseDrv.prewarn <= 4'h1;
    cyc(10);
    chk_pin(rxdSignal_n, 1);
    rd(fst_pkg::ADDR_EVENT, 32'h8, 32'h8);
    senseDrv.prewarn <= 4'h0;
    // Shutdown of every block, wake still seen, then power loss
    senseDrv.shutdown <= 4'hf;
    cyc(8);
    chk_pin(canBusOff, 1);
    chk_pin(canTxEn, 0);
    chk_pin(linStandby, 1);
    chk_pin(sensorLdoEn, 0);
    apb(1'b1, fst_pkg::ADDR_EVENT, 32'h3ff);
    cyc(3);
    chk_pin(rxdSignal_n, 1);
    senseDrv.wakeEvent <= 1'b1;
    cyc(8);
    chk_pin(rxdSignal_n, 0);
    senseDrv.mainPresent <= 1'b0;
    cyc(8);
    chk_pin(rxdSignal_n, 1);
    report_and_stop();
  end
endmodule
